// ### logic/jtl_map.svh
// Constants of the link transmitter: control characters, sequence positions, field codes.
// Assumes inclusion by bare name from every file that needs a fixed value.
//
// Contract
// - Frame filled converter zero first, then upward.
// - All samples of one converter stay together.
// - Control bits appended below each sample.
// - Tail bits pad word to word size.
// - Octets spread over one, two or four lanes.
// - Subclass zero and subclass one both supported.
// - Sync request asserted means K on every enabled lane.
// - Alignment sequence starts at next multiframe boundary.
// - Four multiframes, each R first, A last.
// - First multiframe carries ramp after opening R.
// - Second multiframe: R, Q, then configuration octets.
// - Alignment sequence octets are never scrambled.
// - Configuration fields carry value minus one.
// - Scrambling on after reset, can be disabled.
// - Scrambled FC becomes F, 7C becomes A.
// - Unscrambled repeat of last octet gets replaced.
// - Alignment character insertion on by default, switchable.
// - Balanced 8b/10b with the five control codes.
// - Encoder bypass and output inversion for debugging.
// - Self-synchronising scrambler, 1 + x^14 + x^15.
// - Default 14-bit sample split over two octets.
`ifndef JTL_MAP_SVH
`define JTL_MAP_SVH
`define JTL_CH_R 8'h1C
`define JTL_CH_A 8'h7C
`define JTL_CH_Q 8'h9C
`define JTL_CH_K 8'hBC
`define JTL_CH_F 8'hFC
`define JTL_ILAS_LAST 2'h3
`define JTL_CFG_MF 2'h1
`define JTL_Q_POS 9'h001
`define JTL_CFG_FIRST 9'h002
`define JTL_CFG_END 9'h010
`define JTL_CFG_LID 4'h2
`define JTL_CFG_SUM 4'hD
`define JTL_JESDV 3'h1
`define JTL_SUBCLASS0 3'h0
`define JTL_SUBCLASS1 3'h1
`define JTL_K28_6B 6'h0F
`define JTL_ALT7 4'h7
`define JTL_SCR_SEED 15'h0000
`define JTL_BYP_PAD 2'h0
`endif

// ### logic/jtl_pkg.sv
// Types shared by the link transmitter and its sample buffer.
// Assumes the constants header is included where fixed values are needed.
package jtl_pkg;
	typedef enum logic [1:0] {st_cgs, st_ilas, st_data} jtl_state_t;
endpackage

// ### logic/jtl_stream_if.sv
// Valid/ready word stream between the transmitter core and its sample buffer.
// Assumes one clock; the transfer happens when valid and ready are both high.
`timescale 1ns/1ps
interface jtl_stream_if #(parameter int W = 32);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ### logic/jtl_fifo.sv
// Frame word buffer with valid/ready on both sides.
// Assumes a power-of-two depth; ready drops when full, valid drops when empty.
`timescale 1ns/1ps
module jtl_fifo #(
	parameter int W = 32,
	parameter int D = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	jtl_stream_if.snk wr,
	jtl_stream_if.src rd
);
	import jtl_pkg::*;
	localparam int AW = $clog2(D);

	if (D < 2 || (D & (D - 1)) != 0)
	begin : g_bad_depth
		$error("fifo depth must be a power of two, at least two");
	end

	logic [W-1:0] mem [D];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] cnt;
	wire push = wr.valid && wr.ready;
	wire pop = rd.valid && rd.ready;

	// Honest flags from the fill count
	assign wr.ready = cnt != (AW+1)'(D);
	assign rd.valid = cnt != '0;
	assign rd.data = mem[rp];

	// Storage has no reset; only words already written are ever read
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp] <= wr.data;
	end

	// Pointers and fill count
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end
		else
		begin
			wp <= wp + AW'(push);
			rp <= rp + AW'(pop);
			cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ### logic/jtl_tx_link.sv
// Transmit link layer: frame packing, sync handshake, alignment sequence,
// scrambling, character replacement and 8b/10b encoding for up to four lanes.
// Assumes configuration inputs stay still outside the sync phase.
`timescale 1ns/1ps
`include "jtl_map.svh"
module jtl_tx_link #(
	parameter int M = 2,
	parameter int N = 14,
	parameter int NP = 16,
	parameter int K = 32,
	parameter int LMAX = 4,
	parameter int DEPTH = 16,
	parameter logic [7:0] DID = 8'h5A,
	parameter logic [7:0] BID = 8'h03
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic smp_valid,
	output logic smp_ready,
	input wire logic [M*N-1:0] smp_data,
	input wire logic [M*3-1:0] smp_ctrl,
	input wire logic [1:0] cs_count,
	input wire logic [2:0] lane_count,
	input wire logic subclass_sel,
	input wire logic scramble_dis,
	input wire logic frame_align_char_insert_en,
	input wire logic enc_bypass,
	input wire logic enc_invert,
	input wire logic sync_request_n,
	input wire logic sysref,
	output logic [LMAX*10-1:0] lane_symbol,
	output logic [LMAX-1:0] lane_en,
	output logic local_multiframe_clock,
	output jtl_pkg::jtl_state_t link_state
);
	import jtl_pkg::*;
	localparam int TW = NP - N;
	localparam int FW = M * NP;
	localparam int FO = FW / 8;
	localparam logic [5:0] T6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19,
		6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B, 6'h23,
		6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0E,
		6'h2E, 6'h1E, 6'h2B};
	localparam logic [3:0] T4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
	localparam logic [3:0] K4 [8] = '{4'hB, 4'h0, 4'h0, 4'hC, 4'hD, 4'h5, 4'h0, 4'h7};

	if (TW < 1 || TW > 3 || NP % 8 != 0 || LMAX != 4 || FO % LMAX != 0 || K > 32
		|| K * FO / LMAX < 17)
	begin : g_bad_cfg
		$error("link parameters outside what the packer and sequencer serve");
	end

	// 8b/10b: returns {next disparity, abcdei, fghj}; a is sent first
	function automatic logic [10:0] enc(input logic k, input logic [7:0] d, input logic rd);
		logic [5:0] s6;
		logic [3:0] s4;
		logic rdm;
		logic alt;
		s6 = k ? `JTL_K28_6B : T6[d[4:0]];
		if (rd && (k || $countones(s6) != 3 || d[4:0] == 5'h07))
			s6 = ~s6;
		rdm = rd ^ ($countones(s6) != 3);
		alt = (d[7:5] == 3'h7) && (rdm ? (d[4:0] == 5'h0B || d[4:0] == 5'h0D ||
			d[4:0] == 5'h0E) : (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14));
		s4 = k ? K4[d[7:5]] : (alt ? `JTL_ALT7 : T4[d[7:5]]);
		if (rdm && (k || $countones(s4) != 2 || d[7:5] == 3'h3))
			s4 = ~s4;
		enc = {rdm ^ ($countones(s4) != 2), s6, s4};
	endfunction

	// Scrambler 1 + x^14 + x^15, MSB first; returns {state, octet}
	function automatic logic [22:0] scr(input logic [7:0] d, input logic [14:0] s);
		logic [14:0] st;
		logic [7:0] o;
		st = s;
		o = '0;
		for (int i = 7; i >= 0; i--)
		begin
			o[i] = d[i] ^ st[14] ^ st[13];
			st = {st[13:0], o[i]};
		end
		scr = {st, o};
	endfunction

	// Lane count to octets per frame per lane shift
	function automatic logic [1:0] lane_shift(input logic [2:0] lc);
		lane_shift = (lc == 3'h4) ? 2'h2 : ((lc == 3'h2) ? 2'h1 : 2'h0);
	endfunction

	// Sum of the configuration octets ahead of the checksum
	function automatic logic [7:0] cfg_sum(input logic [103:0] v);
		logic [7:0] s;
		s = '0;
		for (int i = 0; i < 13; i++)
			s = s + v[8*i +: 8];
		cfg_sum = s;
	endfunction

	jtl_stream_if #(.W(FW)) in_if ();
	jtl_stream_if #(.W(FW)) out_if ();

	jtl_state_t st;
	jtl_state_t next_st;
	logic sync1, sync2, sr1, sr2, sr3;
	logic [4:0] fcnt;
	logic [5:0] frm;
	logic [1:0] ilas_mf;
	logic [FW-1:0] frame_word;
	logic [FW-1:0] frame_in;

	// Pack each converter: sample on top, enabled control bits below, zero tail
	for (genvar c = 0; c < M; c++)
	begin : g_conv
		wire [1:0] cs_eff = (32'(cs_count) > TW) ? 2'(TW) : cs_count;
		wire [2:0] cs_mask = 3'(4'h7 << (2'h3 - cs_eff)); // control bit 2 fills first
		wire [2:0] cm = smp_ctrl[3*c +: 3] & cs_mask;
		assign frame_in[FW-1-NP*c -: NP] = {smp_data[N*c +: N], cm[2 -: TW]};
	end

	assign in_if.valid = smp_valid;
	assign in_if.data = frame_in;
	assign smp_ready = in_if.ready;

	jtl_fifo #(.W(FW), .D(DEPTH)) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.wr(in_if.snk),
		.rd(out_if.src)
	);

	// Frame and multiframe position decode
	wire sync_req = !sync2;
	wire [1:0] lsh = lane_shift(lane_count);
	wire [4:0] f_cur = 5'(FO >> lsh);
	wire f_last = fcnt == f_cur - 5'h01;
	wire mf_end = f_last && (frm == 6'(K - 1));
	wire [8:0] oi = 9'(frm) * 9'(f_cur) + 9'(fcnt); // Widen first: frame times F overflows six bits
	wire sysref_edge = sr2 && !sr3 && subclass_sel;
	wire scr_on = !scramble_dis;
	wire pop = f_last && (next_st == st_data);
	assign out_if.ready = pop;

	// Configuration octets, fields as value minus one
	wire [103:0] cfg_w = {DID, BID, 8'h00, {scr_on, 2'h0, 5'(lane_count - 3'h1)},
		{3'h0, f_cur - 5'h01}, {3'h0, 5'(K - 1)}, 8'(M - 1), {cs_count, 1'b0, 5'(N - 1)},
		{subclass_sel ? `JTL_SUBCLASS1 : `JTL_SUBCLASS0, 5'(NP - 1)}, {`JTL_JESDV, 5'h00},
		24'h000000};
	wire [7:0] csum = cfg_sum(cfg_w);

	// Link state sequencing; a sync request wins from any state
	always_comb
	begin
		next_st = st;
		case (st)
			st_cgs: if (mf_end) next_st = st_ilas;
			st_ilas: if (mf_end && ilas_mf == `JTL_ILAS_LAST) next_st = st_data;
			st_data: next_st = st_data;
			default: next_st = st_cgs;
		endcase
		if (sync_req)
			next_st = st_cgs;
	end

	// Two-stage synchronisers for the sync and reference pins
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			{sync1, sync2} <= 2'h0;
			{sr1, sr2, sr3} <= 3'h0;
		end
		else
		begin
			{sync1, sync2} <= {sync_request_n, sync1};
			{sr1, sr2, sr3} <= {sysref, sr1, sr2};
		end
	end

	// Local multiframe counters; a reference edge realigns them in subclass one
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fcnt <= '0;
			frm <= '0;
		end
		else if (sysref_edge || (f_last && mf_end))
		begin
			fcnt <= '0;
			frm <= '0;
		end
		else
		begin
			fcnt <= f_last ? 5'h00 : fcnt + 5'h01;
			frm <= f_last ? frm + 6'h01 : frm;
		end
	end

	// State, sequence count and frame word; an empty buffer sends zero samples
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st <= st_cgs;
			ilas_mf <= '0;
			frame_word <= '0;
			local_multiframe_clock <= 1'b0;
			lane_en <= '0;
		end
		else
		begin
			st <= next_st;
			ilas_mf <= (st == st_ilas && mf_end) ? ilas_mf + 2'h1 : ((st == st_ilas) ? ilas_mf : 2'h0);
			frame_word <= pop ? (out_if.valid ? out_if.data : '0) : frame_word;
			local_multiframe_clock <= mf_end;
			lane_en <= LMAX'((32'h1 << lane_count) - 32'h1);
		end
	end

	assign link_state = st;

	// Per-lane octet selection, scrambling, replacement and encoding
	for (genvar l = 0; l < LMAX; l++)
	begin : g_lane
		logic [9:0] sym;
		logic rd;
		logic [14:0] scr_st;
		logic [7:0] prev;
		wire lane_on = 3'(l) < lane_count;
		wire [4:0] idx = 5'(l * f_cur) + fcnt;
		wire [FW-1:0] shf = FW'(frame_word << {idx, 3'h0});
		wire [7:0] data_oct = shf[FW-1 -: 8];
		wire [22:0] sres = scr(data_oct, scr_st);
		wire [7:0] scr_o = scr_on ? sres[7:0] : data_oct;
		wire rep_scr = scr_on && (mf_end ? scr_o == `JTL_CH_A : scr_o == `JTL_CH_F);
		wire rep_raw = !scr_on && data_oct == prev;
		wire rep = frame_align_char_insert_en && f_last && (rep_scr || rep_raw);
		wire [7:0] rep_ch = mf_end ? `JTL_CH_A : `JTL_CH_F;
		wire [3:0] ci = 4'(oi - `JTL_CFG_FIRST);
		wire [7:0] cfg_oct = (ci == `JTL_CFG_LID) ? 8'(l) :
			((ci == `JTL_CFG_SUM) ? csum + 8'(l) : cfg_w[103 - 8*ci -: 8]);
		wire in_cfg = ilas_mf == `JTL_CFG_MF && oi >= `JTL_CFG_FIRST && oi < `JTL_CFG_END;
		wire is_q = ilas_mf == `JTL_CFG_MF && oi == `JTL_Q_POS;
		wire ilas_k = oi == 9'h000 || mf_end || is_q;
		wire [7:0] ilas_ch = (oi == 9'h000) ? `JTL_CH_R : (mf_end ? `JTL_CH_A : `JTL_CH_Q);
		wire [7:0] ilas_oct = ilas_k ? ilas_ch : (in_cfg ? cfg_oct : oi[7:0]);
		wire kc = (st == st_cgs) || (st == st_ilas && ilas_k) || (st == st_data && rep);
		wire [7:0] oct = (st == st_cgs) ? `JTL_CH_K : ((st == st_ilas) ? ilas_oct :
			(rep ? rep_ch : scr_o));
		wire [10:0] e = enc(kc, oct, rd);
		wire [9:0] raw = enc_bypass ? {oct, `JTL_BYP_PAD} : e[9:0];
		wire [9:0] next_sym = lane_on ? (raw ^ {10{enc_invert}}) : 10'h000;
		wire next_rd = (lane_on && !enc_bypass) ? e[10] : rd;
		wire [14:0] next_scr = (st == st_data && scr_on && lane_on) ? sres[22:8] : scr_st;
		wire [7:0] next_prev = (st == st_data && f_last && lane_on) ? data_oct : prev;

		// Symbol, disparity and scrambler state; the scrambler only moves on user data
		always_ff @(posedge clk or negedge rst_b)
		begin
			if (!rst_b)
			begin
				sym <= '0;
				rd <= 1'b0;
				scr_st <= `JTL_SCR_SEED;
				prev <= '0;
			end
			else
			begin
				sym <= next_sym;
				rd <= next_rd;
				scr_st <= next_scr;
				prev <= next_prev;
			end
		end
		assign lane_symbol[10*l +: 10] = sym;
	end

	// Checks on the sequencer and lane zero
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_ilas_entry;
		(st == st_cgs) ##1 (st == st_ilas);
	endsequence
	sequence s_ilas_step;
		(st == st_ilas && mf_end && !sync_req && ilas_mf != `JTL_ILAS_LAST) ##1 !sync_req;
	endsequence

	ilas_boundary_a: assert property (s_ilas_entry |-> fcnt == 5'h00 && frm == 6'h00)
		else $error("alignment sequence began off a multiframe boundary");
	ilas_length_a: assert property ($rose(st == st_data) |-> $past(st) == st_ilas &&
		$past(ilas_mf) == `JTL_ILAS_LAST && $past(mf_end)) else $error("sequence length wrong");
	ilas_step_a: assert property (s_ilas_step |-> st == st_ilas &&
		ilas_mf == $past(ilas_mf, 2) + 2'h1) else $error("multiframe count did not advance");
	cgs_k_a: assert property (st == st_cgs |-> g_lane[0].kc && g_lane[0].oct == `JTL_CH_K)
		else $error("sync phase sent a non-K character");
	resync_data_a: assert property (sync_req && st == st_data |=> st == st_cgs)
		else $error("sync request ignored during user data");
	cfg_q_a: assert property (st == st_ilas && g_lane[0].is_q |-> g_lane[0].oct == `JTL_CH_Q)
		else $error("second multiframe lacks Q");
	ilas_ramp_a: assert property (st == st_ilas && ilas_mf == 2'h0 && !g_lane[0].ilas_k |->
		g_lane[0].oct == oi[7:0]) else $error("ramp value wrong");
	no_scramble_a: assert property (st != st_data |=> $stable(g_lane[0].scr_st))
		else $error("scrambler moved outside user data");
	replace_fc_a: assert property (st == st_data && scr_on && frame_align_char_insert_en &&
		f_last && !mf_end && g_lane[0].scr_o == `JTL_CH_F |-> g_lane[0].kc)
		else $error("scrambled FC not replaced");
	// Sampled reset keeps the release edge out: the symbol then still holds its reset value
	k_symbol_a: assert property (rst_b && st == st_cgs && !enc_bypass && !enc_invert
		|=> lane_symbol[9:4] == 6'h0F || lane_symbol[9:4] == 6'h30) else $error("bad K symbol");
endmodule

// ### tb/jtl_rx_model.sv
// Receiver stand-in: drives the active-low sync request and counts K on lane 0.
// Assumes lane 0 symbols change on the rising edge; K accepted coded or in bypass form.
`timescale 1ns/1ps
module jtl_rx_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [9:0] lane0,
	input wire logic hold,
	output logic sync_request_n
);
	logic [2:0] k_run;
	// Both disparities of K28.5, and K as it looks with the encoder bypassed
	wire logic is_k = (lane0 == 10'h0FA) || (lane0 == 10'h305) || (lane0 == 10'h2F0);

	// Release only after four good K in a row and once the bench lets go
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			k_run <= 3'h0;
			sync_request_n <= 1'b0;
		end
		else if (hold)
		begin
			k_run <= 3'h0;
			sync_request_n <= 1'b0; // Held far longer than four frames
		end
		else if (!sync_request_n)
		begin
			k_run <= is_k ? ((k_run == 3'h4) ? k_run : k_run + 3'h1) : 3'h0;
			if (k_run == 3'h4)
				sync_request_n <= 1'b1;
		end
	end
endmodule

// ### tb/tb_top.sv
// Bench for the link transmitter: sync, alignment sequence, framing, buffer.
// Assumes the receiver model on lane 0; octet checks run with the encoder bypassed.
`timescale 1ns/1ps
module tb_top;
	import jtl_pkg::*;
	localparam logic [7:0] TB_DID = 8'h3C; // Arbitrary identity value
	localparam logic [7:0] TB_BID = 8'h41; // Arbitrary identity value
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic smp_valid = 1'b0;
	logic [27:0] smp_data = 28'h0;
	logic [5:0] smp_ctrl = 6'h14;
	logic [1:0] cs_count = 2'h2;
	logic [2:0] lane_count = 3'h1;
	logic subclass_sel = 1'b1;
	logic scramble_dis = 1'b0;
	logic frame_align_char_insert_en = 1'b1;
	logic enc_bypass = 1'b0;
	logic enc_invert = 1'b0;
	logic sysref = 1'b0;
	logic hold = 1'b1;
	logic smp_ready;
	logic sync_request_n;
	logic [39:0] lane_symbol;
	logic [3:0] lane_en;
	logic mf_pulse;
	jtl_state_t link_state;
	logic [9:0] sym;
	int errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int last_mf = 0;

	always #20 clk = ~clk;

	// Cycle count and the cycle of the latest multiframe pulse
	always @(posedge clk)
		cyc++;
	always @(negedge clk)
		if (mf_pulse === 1'b1)
			last_mf = cyc;

	jtl_tx_link #(.DID(TB_DID), .BID(TB_BID)) jtl_tx_link_inst (.clk(clk), .rst_b(rst_b),
		.smp_valid(smp_valid),
		.smp_ready(smp_ready), .smp_data(smp_data), .smp_ctrl(smp_ctrl), .cs_count(cs_count),
		.lane_count(lane_count), .subclass_sel(subclass_sel), .scramble_dis(scramble_dis),
		.frame_align_char_insert_en(frame_align_char_insert_en), .enc_bypass(enc_bypass),
		.enc_invert(enc_invert), .sync_request_n(sync_request_n), .sysref(sysref),
		.lane_symbol(lane_symbol), .lane_en(lane_en), .local_multiframe_clock(mf_pulse),
		.link_state(link_state));
	jtl_rx_model jtl_rx_model_inst (.clk(clk), .rst_b(rst_b), .lane0(lane_symbol[9:0]),
		.hold(hold), .sync_request_n(sync_request_n));

	task automatic print_verdict();
		$display("Checks made: %0d, errors: %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk_val(input logic [9:0] got, input logic [9:0] exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_oct(input logic [7:0] got, input logic [7:0] exp, input int idx);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %0t: octet %0d got %h expected %h", $time, idx, got, exp);
		end
	endtask

	// Frame i: converter 0 then 1, each sample with two control bits below it
	function automatic logic [31:0] frame_word(input int i);
		logic [13:0] s0;
		logic [13:0] s1;
		s0 = 14'h0C00 + 14'(i);
		s1 = {8'h55, 6'((i == 4) ? 4 : i + 1)}; // Frames 3 and 4 end alike
		return {s0, 2'b10, s1, 2'b01};
	endfunction

	// Sixteen words fill the buffer; the seventeenth is left waiting and refused
	task automatic fill();
		logic [31:0] w;
		for (int i = 0; i < 17; i++)
		begin
			w = frame_word(i);
			@(posedge clk);
			smp_valid <= 1'b1;
			smp_data <= {w[15:2], w[31:18]};
		end
		repeat (3) @(negedge clk);
		chk_val({9'h000, smp_ready}, 10'h000, "full buffer");
		@(posedge clk);
		smp_valid <= 1'b0;
	endtask

	// Release sync, then follow 4 multiframes and, unscrambled, one of user data
	task automatic run_link(input logic scr_dis, input logic sub);
		logic [7:0] cfg [14];
		logic [7:0] exp;
		logic [7:0] raw;
		logic [7:0] prev;
		logic [31:0] w;
		int n;
		int oi;
		int f;
		cfg = '{TB_DID, TB_BID, 8'h00, {~scr_dis, 7'h00}, 8'h03, 8'h1F, 8'h01, 8'h8D,
			{2'h0, sub, 5'h0F}, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int j = 0; j < 13; j++)
			cfg[13] = cfg[13] + cfg[j];
		@(posedge clk);
		scramble_dis <= scr_dis;
		subclass_sel <= sub;
		hold <= 1'b0;
		n = 0;
		@(negedge clk);
		while (lane_symbol[9:2] !== 8'h1C && n < 3000)
		begin
			@(negedge clk);
			n++;
		end
		chk_val((n < 3000 && cyc - last_mf <= 2) ? 10'h001 : 10'h000, 10'h001, "start");
		for (n = 0; n < (scr_dis ? 640 : 512); n++)
		begin
			oi = n % 128;
			f = (n - 512) / 4;
			exp = (oi == 0) ? 8'h1C : (oi == 127) ? 8'h7C : 8'(oi);
			if (n / 128 == 1 && oi == 1)
				exp = 8'h9C;
			if (n / 128 == 1 && oi > 1 && oi < 16)
				exp = cfg[oi - 2];
			w = (f < 16) ? frame_word(f) : 32'h0;
			raw = w[31 - 8 * (n % 4) -: 8];
			if (n >= 512)
				exp = (n % 4 == 3 && f > 0 && raw == prev) ? ((f == 31) ? 8'h7C : 8'hFC) : raw;
			if (n % 4 == 3)
				prev = raw;
			chk_oct(lane_symbol[9:2], exp, n);
			if (n == 1 || n == 520)
				chk_val({8'h00, link_state}, {8'h00, (n == 1) ? st_ilas : st_data}, "state");
			@(negedge clk);
		end
		@(posedge clk);
		hold <= 1'b1;
		repeat (6) @(negedge clk);
		chk_val({8'h00, link_state}, {8'h00, st_cgs}, "resync");
		chk_val(lane_symbol[9:0], 10'h2F0, "resync K");
	endtask

	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk);
			lane_count <= 3'(1 << i);
			repeat (4) @(negedge clk);
			chk_val({6'h00, lane_en}, 10'((1 << (1 << i)) - 1), "lanes");
		end
		// Lane 0 last, so the balance check below follows lane 0 itself
		for (int l = 3; l >= 0; l--)
		begin
			sym = lane_symbol[10 * l +: 10];
			chk_val(sym, (sym == 10'h305) ? 10'h305 : 10'h0FA, "K code");
		end
		@(negedge clk);
		chk_val(lane_symbol[9:0], ~sym, "K balance");
		@(posedge clk);
		enc_bypass <= 1'b1;
		enc_invert <= 1'b1;
		lane_count <= 3'h1;
		sysref <= 1'b1;
		repeat (4) @(negedge clk);
		chk_val(lane_symbol[9:0], 10'h10F, "inverted bypass");
		@(posedge clk);
		enc_invert <= 1'b0;
		sysref <= 1'b0;
		fill();
		run_link(1'b0, 1'b1);
		// Reset in mid-run: the first run popped two words, so start the buffer empty again
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		fill();
		run_link(1'b1, 1'b0);
		print_verdict();
	end
endmodule
